//--- verilog/rone_exec.sv
// Decode and execute of load-option, no-operation and the two returns
`timescale 1ns/1ps
module rone_exec import rone_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Instruction from the fetch path
  input wire logic [INSN_W-1:0] insn_word,
  input wire logic insn_valid,
  output logic insn_ready_q,
  // Return stack
  input wire logic [PC_W-1:0] top_of_stack,
  output logic stack_pop_q,
  // File register write port and working register load from the core
  input wire logic file_wr_en,
  input wire logic [FILE_A_W-1:0] file_addr,
  input wire logic [DATA_W-1:0] file_wr_data,
  input wire logic work_wr_en,
  input wire logic [DATA_W-1:0] work_wr_data,
  // Interrupt entry clears the global enable
  input wire logic global_enable_clear,
  // Core state
  output logic [DATA_W-1:0] work_q,
  output logic [DATA_W-1:0] option_q,
  output logic [PC_W-1:0] pc_q,
  output logic global_interrupt_enable_q
);

  rone_state_e state_q;
  logic take;
  logic dec_opt;
  logic dec_rfi;
  logic dec_rlw;
  logic dec_no_op;
  logic dec_ret;
  logic opt_file_hit;

  // Instruction accepted this cycle and its decode
  assign take = insn_valid && insn_ready_q;
  assign dec_opt = take && rone_is_load_option(insn_word);
  assign dec_rfi = take && rone_is_return_from_int(insn_word);
  assign dec_rlw = take && rone_is_retlit(insn_word);
  assign dec_no_op = take && rone_is_no_op(insn_word);

  // Either return pops the stack and stalls one cycle
  assign dec_ret = dec_rfi || dec_rlw;

  // Plain file write aimed at the option register
  assign opt_file_hit = file_wr_en && (file_addr == OPTION_FILE_ADDR);

  // Sequencer: returns hold the pipe for a second cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_ISSUE;
      insn_ready_q <= 1'h0;
    end else begin
      case (state_q)
        ST_ISSUE: begin
          if (dec_ret) begin
            state_q <= ST_SECOND;
            insn_ready_q <= 1'h0;
          end else begin
            insn_ready_q <= 1'h1;
          end
        end
        ST_SECOND: begin
          state_q <= ST_ISSUE;
          insn_ready_q <= 1'h1;
        end
        default: begin
          state_q <= ST_ISSUE;
          insn_ready_q <= 1'h0;
        end
      endcase
    end
  end

  // Program counter: pop on returns, step on every other accepted instruction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= RST_PC;
      stack_pop_q <= 1'h0;
    end else begin
      stack_pop_q <= dec_ret;
      if (dec_ret) begin
        pc_q <= top_of_stack;
      end else if (take) begin
        pc_q <= pc_q + 13'h0001;
      end
    end
  end

  // Working register: literal from return, else core load only in a cycle with no instruction accepted
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      work_q <= RST_WORK;
    end else if (dec_rlw) begin
      work_q <= insn_word[7:0];
    end else if (work_wr_en && !take) begin
      work_q <= work_wr_data;
    end
  end

  // Option register: load-option opcode or plain file write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      option_q <= RST_OPTION;
    end else if (dec_opt) begin
      option_q <= work_q;
    end else if (opt_file_hit) begin
      option_q <= file_wr_data;
    end
  end

  // Global enable: return from interrupt sets it and wins over interrupt entry
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      global_interrupt_enable_q <= RST_GLOBAL_EN;
    end else if (dec_rfi) begin
      global_interrupt_enable_q <= 1'h1;
    end else if (global_enable_clear) begin
      global_interrupt_enable_q <= 1'h0;
    end
  end

  // Checks on the executed behaviour
  load_option_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    dec_opt |=> option_q == $past(work_q) && insn_ready_q)
    else $error("option not loaded from working register");

  option_file_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (opt_file_hit && !dec_opt) |=> option_q == $past(file_wr_data))
    else $error("option file write lost");

  rfi_pop_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    dec_rfi |=> pc_q == $past(top_of_stack) && stack_pop_q
    && !insn_ready_q ##1 insn_ready_q && !stack_pop_q)
    else $error("return from interrupt sequence wrong");

  rfi_global_en_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    dec_rfi |=> global_interrupt_enable_q)
    else $error("global enable not set on return");

  rlw_work_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    dec_rlw |=> work_q == $past(insn_word[7:0]))
    else $error("literal not loaded into working register");

  rlw_pop_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    dec_rlw |=> pc_q == $past(top_of_stack) && !insn_ready_q
    ##1 insn_ready_q && $stable(pc_q))
    else $error("return with literal sequence wrong");

  no_op_pc_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (dec_no_op && !file_wr_en && !global_enable_clear)
    |=> pc_q == $past(pc_q) + 13'h0001 && $stable(work_q)
    && $stable(option_q) && $stable(global_interrupt_enable_q)
    && insn_ready_q && !stack_pop_q)
    else $error("no-operation changed state");

  // Guards on the stall, the holds and the enable priority
  pop_pulse_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    stack_pop_q |=> !stack_pop_q)
    else $error("stack pop longer than one cycle");

  second_stall_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q == ST_SECOND) |-> !insn_ready_q && stack_pop_q)
    else $error("second return cycle not stalled");

  stall_release_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q == ST_SECOND) |=> insn_ready_q && state_q == ST_ISSUE)
    else $error("stall not released after second cycle");

  rfi_regs_kept_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (dec_rfi && !opt_file_hit) |=> $stable(work_q) && $stable(option_q))
    else $error("return from interrupt changed a register");

  rlw_enable_kept_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (dec_rlw && !global_enable_clear && !opt_file_hit)
    |=> $stable(global_interrupt_enable_q) && $stable(option_q))
    else $error("return with literal changed enable or option");

  pc_step_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (take && !dec_ret) |=> pc_q == $past(pc_q) + 13'h0001 && !stack_pop_q)
    else $error("program counter did not step by one");

  pc_hold_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    !take |=> $stable(pc_q))
    else $error("program counter moved with no instruction");

  option_hold_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!dec_opt && !opt_file_hit) |=> $stable(option_q))
    else $error("option register changed with no load");

  work_hold_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!dec_rlw && !(work_wr_en && !take)) |=> $stable(work_q))
    else $error("working register changed with no load");

  enable_clear_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (global_enable_clear && !dec_rfi) |=> !global_interrupt_enable_q)
    else $error("global enable not cleared on interrupt entry");

  enable_hold_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!dec_rfi && !global_enable_clear)
    |=> $stable(global_interrupt_enable_q))
    else $error("global enable changed with no cause");

endmodule : rone_exec

//--- verilog/rone_pkg.sv
// Constants, opcodes and decode helpers for the return/option/nop executor
package rone_pkg;

  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FILE_A_W = 7;

  // Opcode patterns and don't-care masks
  localparam logic [13:0] OP_LOAD_OPTION = 14'h0062;
  localparam logic [13:0] OP_RETURN_FROM_INT = 14'h0009;
  localparam logic [13:0] OP_NO_OPERATION = 14'h0000;
  localparam logic [13:0] MASK_NO_OPERATION = 14'h3f9f;
  localparam logic [13:0] OP_RETURN_LITERAL = 14'h3400;
  localparam logic [13:0] MASK_RETURN_LITERAL = 14'h3c00;

  // File-map position of the option register
  localparam logic [6:0] OPTION_FILE_ADDR = 7'h01;

  // Values after reset
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic RST_GLOBAL_EN = 1'h0;

  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_ISSUE = 2'h0,
    ST_SECOND = 2'h1
  } rone_state_e;

  // Decoders shared by the execute logic and its checks
  function automatic logic rone_is_load_option(input logic [13:0] insn);
    return insn == OP_LOAD_OPTION;
  endfunction : rone_is_load_option

  function automatic logic rone_is_return_from_int(input logic [13:0] insn);
    return insn == OP_RETURN_FROM_INT;
  endfunction : rone_is_return_from_int

  function automatic logic rone_is_retlit(input logic [13:0] insn);
    return (insn & MASK_RETURN_LITERAL) == OP_RETURN_LITERAL;
  endfunction : rone_is_retlit

  function automatic logic rone_is_no_op(input logic [13:0] insn);
    return (insn & MASK_NO_OPERATION) == OP_NO_OPERATION;
  endfunction : rone_is_no_op

endpackage : rone_pkg

//--- tb/rone_exec_tb.sv
// Randomised bench comparing the executor with a reference model
`timescale 1ns/1ps
module rone_exec_tb import rone_pkg::*;;
  logic clock, reset_n, insn_valid, file_wr_en, work_wr_en;
  logic global_enable_clear;
  logic [13:0] insn_word;
  logic [12:0] top_of_stack;
  logic [6:0] file_addr;
  logic [7:0] file_wr_data, work_wr_data;
  logic insn_ready_q, stack_pop_q, global_interrupt_enable_q;
  logic [7:0] work_q, option_q;
  logic [12:0] pc_q;
  logic [31:0] r, r2;
  int seed = 18462;
  int miscompares = 0, compares = 0, cyc = 0, kind = 0;
  int m_w, m_o, m_pc, m_g, m_rdy, m_pop;
  bit tk, ret;
  rone_exec uut (.clock(clock), .reset_n(reset_n), .insn_word(insn_word),
    .insn_valid(insn_valid), .insn_ready_q(insn_ready_q),
    .top_of_stack(top_of_stack), .stack_pop_q(stack_pop_q),
    .file_wr_en(file_wr_en), .file_addr(file_addr),
    .file_wr_data(file_wr_data), .work_wr_en(work_wr_en),
    .work_wr_data(work_wr_data),
    .global_enable_clear(global_enable_clear), .work_q(work_q),
    .option_q(option_q), .pc_q(pc_q),
    .global_interrupt_enable_q(global_interrupt_enable_q));
  // Clock and hang limit
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Reference model, one instruction cycle per edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      m_w = 0; m_o = 255; m_pc = 0; m_g = 0; m_rdy = 0; m_pop = 0;
    end else begin
      tk = insn_valid && m_rdy;
      ret = tk && (kind == 2 || kind == 3);
      if (tk && kind == 0) m_o = m_w;
      else if (file_wr_en && file_addr == 7'h01) m_o = file_wr_data;
      if (tk && kind == 3) m_w = insn_word[7:0];
      else if (work_wr_en && !tk) m_w = work_wr_data;
      if (ret) m_pc = top_of_stack;
      else if (tk) m_pc = (m_pc + 1) % 8192;
      if (tk && kind == 2) m_g = 1;
      else if (global_enable_clear) m_g = 0;
      m_pop = ret;
      m_rdy = !ret;
    end
  end
  // Stimulus at the falling edge, checks first
  initial begin
    reset_n = 0; insn_valid = 0; insn_word = 14'h0000; top_of_stack = 0;
    file_wr_en = 0; file_addr = 0; file_wr_data = 0; work_wr_en = 0;
    work_wr_data = 0; global_enable_clear = 0;
    repeat (16) @(negedge clock);
    reset_n = 1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clock);
      check("work", work_q, 16'(m_w));
      check("option", option_q, 16'(m_o));
      check("pc", pc_q, 16'(m_pc));
      check("global_en", global_interrupt_enable_q, 16'(m_g));
      check("ready", insn_ready_q, 16'(m_rdy));
      check("pop", stack_pop_q, 16'(m_pop));
      if (i == 1000) begin
        reset_n = 0;
        repeat (2) @(negedge clock);
        reset_n = 1;
      end
      r = $random(seed);
      r2 = $random(seed);
      case (r[2:0])
        3'h1: begin kind = 1; insn_word = {7'h00, r[4:3], 5'h00}; end
        3'h2: begin kind = 2; insn_word = 14'h0009; end
        3'h3, 3'h4: begin kind = 3; insn_word = {4'hd, r[9:0]}; end
        3'h5: begin kind = 4; insn_word = {7'h01, r[6:0]}; end
        default: begin kind = 0; insn_word = 14'h0062; end
      endcase
      insn_valid = r[12] | r[13];
      file_wr_en = r[14] & r[15];
      file_addr = r[16] ? 7'h01 : r[23:17];
      file_wr_data = r[31:24];
      work_wr_en = r[10] & r[11];
      work_wr_data = r2[7:0];
      global_enable_clear = r[19] & r[20];
      top_of_stack = r2[20:8];
    end
    stop_test();
  end
endmodule : rone_exec_tb
